// >>> hw/ram_io_timer_edge_irq_unit.sv
// Bus decode, ports, interval timer control and interrupt flags
`timescale 1ns/1ps
module ram_io_timer_edge_irq_unit
   import riot_pkg::*;
#(
   parameter int DW = 8             // Data and port width
)(
   input wire logic clk,
   input wire logic nrst,
   input wire logic init_in_n,      // Synchronous initialisation
   input wire bus_req_s bus_req,    // Processor bus, one per clock
   output logic [DW-1:0] rdata,     // Read data, valid while rdata_oe
   output logic rdata_oe,           // Data bus drive enable
   output logic ram_select,         // RAM array access this cycle
   input wire logic [DW-1:0] port_a_in,   // Port A pin levels
   output logic [DW-1:0] port_a_out,
   output logic [DW-1:0] port_a_oe, // High drives the pin
   output logic [DW-1:0] port_b_out,
   output logic [DW-1:0] port_b_oe,
   output logic irq_n_out,          // Open-drain level, always low
   output logic irq_n_oe            // High pulls interrupt line low
);

   // ----------------------------------------------------------------
   // Access decode
   // ----------------------------------------------------------------
   logic chip_on;          // Both chip selects active
   logic io_sel;           // I/O and timer section
   logic timer_sel;        // Timer half of section
   logic port_sel;         // Port register half of section
   logic rd;               // Read cycle
   logic wr;               // Write cycle
   logic timer_load;       // Count write
   logic timer_rd;         // Count read
   logic flag_rd;          // Flag register read
   logic edge_wr;          // Edge control write
   logic [1:0] port_code;  // Port register code

   assign chip_on = bus_req.chip_select_high_active
                    && !bus_req.chip_select_low_active;
   // RAM needs the space select low
   assign ram_select = chip_on && !bus_req.memory_space_select;
   // I/O and timer need it high
   assign io_sel = chip_on && bus_req.memory_space_select;
   // Split section on A2
   assign timer_sel = io_sel && bus_req.addr[A_TIMER_SEL];
   assign port_sel = io_sel && !bus_req.addr[A_TIMER_SEL];
   assign rd = bus_req.rw;
   assign wr = !bus_req.rw;
   assign port_code = bus_req.addr[A_PORT_LO +: 2];

   // Timer section decode
   assign timer_load = timer_sel && wr && bus_req.addr[A_TIMER_WR];
   assign edge_wr = timer_sel && wr && !bus_req.addr[A_TIMER_WR];
   assign timer_rd = timer_sel && rd && !bus_req.addr[A_FLAG_SEL];
   assign flag_rd = timer_sel && rd && bus_req.addr[A_FLAG_SEL];

   // ----------------------------------------------------------------
   // Port registers
   // ----------------------------------------------------------------
   logic [DW-1:0] pa_out_ff, nxt_pa_out;  // Port A output
   logic [DW-1:0] pa_dir_ff, nxt_pa_dir;  // Port A direction
   logic [DW-1:0] pb_out_ff, nxt_pb_out;  // Port B output
   logic [DW-1:0] pb_dir_ff, nxt_pb_dir;  // Port B direction

   // Next port values
   always_comb
   begin
      nxt_pa_out = pa_out_ff;
      nxt_pa_dir = pa_dir_ff;
      nxt_pb_out = pb_out_ff;
      nxt_pb_dir = pb_dir_ff;
      if (!init_in_n)
      begin
         // Every pin back to input
         nxt_pa_out = PORT_RST;
         nxt_pa_dir = PORT_RST;
         nxt_pb_out = PORT_RST;
         nxt_pb_dir = PORT_RST;
      end
      else if (port_sel && wr)
      begin
         // Register chosen by A1 A0
         unique case (port_code)
            PORT_A_OUT: nxt_pa_out = bus_req.wdata;
            PORT_A_DIR: nxt_pa_dir = bus_req.wdata;
            PORT_B_OUT: nxt_pb_out = bus_req.wdata;
            PORT_B_DIR: nxt_pb_dir = bus_req.wdata;
         endcase
      end
   end

   // Register port state
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pa_out_ff <= PORT_RST;
         pa_dir_ff <= PORT_RST;
         pb_out_ff <= PORT_RST;
         pb_dir_ff <= PORT_RST;
      end
      else
      begin
         pa_out_ff <= nxt_pa_out;
         pa_dir_ff <= nxt_pa_dir;
         pb_out_ff <= nxt_pb_out;
         pb_dir_ff <= nxt_pb_dir;
      end
   end

   // Pins follow the registers
   assign port_a_out = pa_out_ff;
   assign port_a_oe = pa_dir_ff;
   assign port_b_out = pb_out_ff;
   assign port_b_oe = pb_dir_ff;

   // ----------------------------------------------------------------
   // Interval timer
   // ----------------------------------------------------------------
   logic [DW-1:0] count;      // Live count
   logic expire;              // Count passed zero this clock
   logic timer_flag_ff;       // Timer expiry flag
   logic nxt_timer_flag;
   logic timer_irq_en_ff;     // Timer drives interrupt
   logic nxt_timer_irq_en;

   // Count and prescale load on timer write
   interval_count_unit #(
      .CW(DW)
   ) u_count (
      .clk(clk),
      .nrst(nrst),
      .load(timer_load),
      .load_value(bus_req.wdata),
      .pre_sel(port_code),
      .fast(timer_flag_ff),   // Divide by one after expiry
      .count(count),
      .expire(expire)
   );

   // Next timer flag and enable
   always_comb
   begin
      nxt_timer_flag = timer_flag_ff;
      nxt_timer_irq_en = timer_irq_en_ff;
      if (!init_in_n)
      begin
         // Interrupt capability off during init
         nxt_timer_irq_en = IRQ_EN_RST;
      end
      else if (timer_load || timer_rd)
      begin
         // Count write or count read sets enable from A3
         nxt_timer_irq_en = bus_req.addr[A_TIMER_IRQ];
      end
      if (timer_load)
      begin
         // Write starts a new interval, flag cleared
         nxt_timer_flag = 1'b0;
      end
      else if (expire)
      begin
         // Set wins over a read in the same clock
         nxt_timer_flag = 1'b1;
      end
      else if (timer_rd)
      begin
         // Read clears the flag
         nxt_timer_flag = 1'b0;
      end
   end

   // Register timer flag and enable
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         timer_flag_ff <= 1'b0;
         timer_irq_en_ff <= IRQ_EN_RST;
      end
      else
      begin
         timer_flag_ff <= nxt_timer_flag;
         timer_irq_en_ff <= nxt_timer_irq_en;
      end
   end

   // ----------------------------------------------------------------
   // Edge sense on port A top bit
   // ----------------------------------------------------------------
   logic edge_pin;            // Pin level, whatever its direction
   logic pin_prev_ff;         // Level one clock ago
   logic nxt_pin_prev;
   logic edge_pol_ff;         // High rising, low falling
   logic nxt_edge_pol;
   logic edge_irq_en_ff;      // Edge drives interrupt
   logic nxt_edge_irq_en;
   logic edge_flag_ff;        // Edge event flag
   logic nxt_edge_flag;
   logic edge_hit;            // Active transition this clock

   // Pin sensed as input even when driven
   assign edge_pin = port_a_in[DW-1];

   // Active transition for chosen polarity
   assign edge_hit = edge_pol_ff ? (edge_pin && !pin_prev_ff)
                                 : (!edge_pin && pin_prev_ff);

   // Next edge control and flag
   always_comb
   begin
      nxt_pin_prev = edge_pin;
      nxt_edge_pol = edge_pol_ff;
      nxt_edge_irq_en = edge_irq_en_ff;
      nxt_edge_flag = edge_flag_ff;
      if (!init_in_n)
      begin
         // Init: disabled, falling edge
         nxt_edge_pol = EDGE_POL_RST;
         nxt_edge_irq_en = IRQ_EN_RST;
      end
      else if (edge_wr)
      begin
         // Address alone programs it, data ignored
         nxt_edge_irq_en = bus_req.addr[A_EDGE_EN];
         nxt_edge_pol = bus_req.addr[A_EDGE_POL];
      end
      if (edge_hit)
      begin
         // Set even with interrupt disabled, wins over clear
         nxt_edge_flag = 1'b1;
      end
      else if (flag_rd)
      begin
         // Flag register read clears it
         nxt_edge_flag = 1'b0;
      end
   end

   // Register edge state
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pin_prev_ff <= 1'b0;
         edge_pol_ff <= EDGE_POL_RST;
         edge_irq_en_ff <= IRQ_EN_RST;
         edge_flag_ff <= 1'b0;
      end
      else
      begin
         pin_prev_ff <= nxt_pin_prev;
         edge_pol_ff <= nxt_edge_pol;
         edge_irq_en_ff <= nxt_edge_irq_en;
         edge_flag_ff <= nxt_edge_flag;
      end
   end

   // ----------------------------------------------------------------
   // Interrupt output
   // ----------------------------------------------------------------
   // Each flag reaches the line only while enabled
   assign irq_n_oe = (timer_flag_ff && timer_irq_en_ff)
                     || (edge_flag_ff && edge_irq_en_ff);
   assign irq_n_out = 1'b0;

   // ----------------------------------------------------------------
   // Read data path
   // ----------------------------------------------------------------
   logic [DW-1:0] rd_mux;          // Selected read value
   logic [DW-1:0] flag_word;       // Flag register image
   logic [DW-1:0] rdata_ff, nxt_rdata;
   logic rdata_oe_ff, nxt_rdata_oe;

   // Two flags only, other bits zero
   always_comb
   begin
      flag_word = '0;
      flag_word[FLAG_TIMER_BIT] = timer_flag_ff;
      flag_word[FLAG_EDGE_BIT] = edge_flag_ff;
   end

   // Pick read source
   always_comb
   begin
      rd_mux = '0;
      if (port_sel)
      begin
         unique case (port_code)
            PORT_A_OUT: rd_mux = port_a_in;   // Port A reads pins
            PORT_A_DIR: rd_mux = pa_dir_ff;
            PORT_B_OUT: rd_mux = pb_out_ff;   // Port B reads register
            PORT_B_DIR: rd_mux = pb_dir_ff;
         endcase
      end
      else if (flag_rd)
      begin
         rd_mux = flag_word;
      end
      else if (timer_rd)
      begin
         rd_mux = count;
      end
   end

   // Capture read data; bus released during init
   always_comb
   begin
      nxt_rdata_oe = init_in_n && io_sel && rd;
      nxt_rdata = nxt_rdata_oe ? rd_mux : rdata_ff;
   end

   // Register read data
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rdata_ff <= '0;
         rdata_oe_ff <= 1'b0;
      end
      else
      begin
         rdata_ff <= nxt_rdata;
         rdata_oe_ff <= nxt_rdata_oe;
      end
   end

   assign rdata = rdata_ff;
   assign rdata_oe = rdata_oe_ff;

endmodule // ram_io_timer_edge_irq_unit

// >>> hw/riot_pkg.sv
// Shared constants and bus carrier for the RAM, I/O and timer unit
package riot_pkg;

   // ----------------------------------------------------------------
   // Address line positions
   // ----------------------------------------------------------------
   localparam int A_PORT_LO = 0;     // Port register code, low bit
   localparam int A_EDGE_POL = 0;    // Edge polarity on control write
   localparam int A_EDGE_EN = 1;     // Edge interrupt enable on write
   localparam int A_FLAG_SEL = 0;    // High reads flags, low reads count
   localparam int A_TIMER_SEL = 2;   // High picks timer, low picks ports
   localparam int A_TIMER_IRQ = 3;   // Timer interrupt enable
   localparam int A_TIMER_WR = 4;    // High loads count, low edge control

   // ----------------------------------------------------------------
   // Port register codes on the two low address lines
   // ----------------------------------------------------------------
   localparam logic [1:0] PORT_A_OUT = 2'h0;
   localparam logic [1:0] PORT_A_DIR = 2'h1;
   localparam logic [1:0] PORT_B_OUT = 2'h2;
   localparam logic [1:0] PORT_B_DIR = 2'h3;

   // ----------------------------------------------------------------
   // Prescale codes and their divide masks (1T, 8T, 64T, 1024T)
   // ----------------------------------------------------------------
   localparam logic [1:0] PRE_1T = 2'h0;
   localparam logic [1:0] PRE_8T = 2'h1;
   localparam logic [1:0] PRE_64T = 2'h2;
   localparam logic [1:0] PRE_1024T = 2'h3;
   localparam int PRE_W = 10;        // Prescaler width for 1024T
   localparam logic [PRE_W-1:0] PRE_MASK_1T = 10'h000;
   localparam logic [PRE_W-1:0] PRE_MASK_8T = 10'h007;
   localparam logic [PRE_W-1:0] PRE_MASK_64T = 10'h03f;
   localparam logic [PRE_W-1:0] PRE_MASK_1024T = 10'h3ff;

   // ----------------------------------------------------------------
   // Flag register layout
   // ----------------------------------------------------------------
   localparam int FLAG_TIMER_BIT = 7;
   localparam int FLAG_EDGE_BIT = 6;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] PORT_RST = 8'h00;   // All pins inputs
   localparam logic [7:0] COUNT_RST = 8'h00;
   localparam logic EDGE_POL_RST = 1'b0;      // Falling edge
   localparam logic IRQ_EN_RST = 1'b0;

   // ----------------------------------------------------------------
   // Processor bus request, sampled once per clock
   // ----------------------------------------------------------------
   typedef struct packed {
      logic chip_select_high_active;  // Active high select
      logic chip_select_low_active;   // Active low select
      logic memory_space_select;      // Low RAM, high I/O and timer
      logic rw;                       // High read, low write
      logic [6:0] addr;               // Address lines
      logic [7:0] wdata;              // Write data
   } bus_req_s;

endpackage

// >>> hw/interval_count_unit.sv
// Eight-bit interval counter with selectable prescale
`timescale 1ns/1ps
module interval_count_unit
   import riot_pkg::*;
#(
   parameter int CW = 8            // Counter width
)(
   input wire logic clk,
   input wire logic nrst,
   input wire logic load,          // Load count and prescale
   input wire logic [CW-1:0] load_value,
   input wire logic [1:0] pre_sel,
   input wire logic fast,          // Count every clock after expiry
   output logic [CW-1:0] count,
   output logic expire             // Pulse as count passes zero
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [CW-1:0] count_ff, nxt_count;     // Interval count
   logic [PRE_W-1:0] pre_ff, nxt_pre;      // Prescale down counter
   logic [PRE_W-1:0] mask_ff, nxt_mask;    // Reload of prescaler
   logic tick;                             // One count interval done
   logic [PRE_W-1:0] sel_mask;             // Mask for requested code

   // Decode prescale code to reload value
   always_comb
   begin
      unique case (pre_sel)
         PRE_1T: sel_mask = PRE_MASK_1T;
         PRE_8T: sel_mask = PRE_MASK_8T;
         PRE_64T: sel_mask = PRE_MASK_64T;
         PRE_1024T: sel_mask = PRE_MASK_1024T;
      endcase
   end

   // Tick at prescale end, or every clock after expiry
   assign tick = fast || (pre_ff == '0);

   // Next count and prescaler
   always_comb
   begin
      nxt_count = count_ff;
      nxt_pre = pre_ff;
      nxt_mask = mask_ff;
      expire = 1'b0;
      if (load)
      begin
         // Fresh interval with the new divide
         nxt_count = load_value;
         nxt_mask = sel_mask;
         nxt_pre = sel_mask;
      end
      else
      begin
         nxt_pre = (pre_ff == '0) ? mask_ff : pre_ff - 1'b1;
         if (tick)
         begin
            // Passing zero wraps to all ones
            nxt_count = count_ff - 1'b1;
            expire = (count_ff == '0) && !fast;
         end
      end
   end

   // Register the counter state
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         count_ff <= COUNT_RST;
         pre_ff <= PRE_MASK_1T;
         mask_ff <= PRE_MASK_1T;
      end
      else
      begin
         count_ff <= nxt_count;
         pre_ff <= nxt_pre;
         mask_ff <= nxt_mask;
      end
   end

   assign count = count_ff;

endmodule // interval_count_unit

// >>> bench/cpu_bus_model.sv
// Processor bus master model driving the unit's register bus
`timescale 1ns/1ps
module cpu_bus_model
   import riot_pkg::*;
(
   input wire logic clk,
   input wire logic [7:0] rdata,
   input wire logic rdata_oe,
   output bus_req_s bus_req
);
   // ---------------------------------------------------------------
   // Bus cycles
   // ---------------------------------------------------------------
   // Deselected bus from time zero
   initial bus_req = '0;

   // One access: drive, taken at the rising edge, answer read after it
   task automatic xfer(input logic [2:0] sel, input logic rw, input logic [6:0] a,
      input logic [7:0] d, output logic [7:0] q, output logic oe);
      @(negedge clk);
      bus_req <= '{sel[2], sel[1], sel[0], rw, a, d};
      @(posedge clk);
      @(negedge clk);
      q = rdata;
      oe = rdata_oe;
      // Released lines wander so stale values are never trusted
      bus_req <= '{1'b0, 1'b1, ~sel[0], 1'b1, ~a, ~d};
   endtask
endmodule // cpu_bus_model

// >>> bench/riot_chk.sv
// Concurrent checks on decode, ports and flags of the unit
`timescale 1ns/1ps
module riot_chk
   import riot_pkg::*;
#(
   parameter int DW = 8 // Data and port width
)(
   input wire logic clk,
   input wire logic nrst,
   input wire logic init_in_n,
   input wire bus_req_s bus_req,
   input wire logic [DW-1:0] rdata,
   input wire logic rdata_oe,
   input wire logic ram_select,
   input wire logic [DW-1:0] port_a_in,
   input wire logic [DW-1:0] port_a_out,
   input wire logic [DW-1:0] port_a_oe,
   input wire logic [DW-1:0] port_b_out,
   input wire logic [DW-1:0] port_b_oe,
   input wire logic irq_n_out,
   input wire logic irq_n_oe
);
   // ---------------------------------------------------------------
   // Helper decode
   // ---------------------------------------------------------------
   logic [6:0] a; // Address lines
   logic io; // I/O and timer section taken
   logic fl; // Flag register read
   assign a = bus_req.addr;
   assign io = bus_req.chip_select_high_active & ~bus_req.chip_select_low_active
      & bus_req.memory_space_select & init_in_n;
   assign fl = io & bus_req.rw & a[2] & a[0];

   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);

   // ---------------------------------------------------------------
   // Sequences
   // ---------------------------------------------------------------
   // Flag read with the edge pin quiet
   sequence s_flag_rd;
      fl && $stable(port_a_in[7]);
   endsequence
   // Timer access with its interrupt turned off
   sequence s_tmr_off;
      io && a[2] && !a[3] && (bus_req.rw ? !a[0] : a[4]);
   endsequence
   // Edge control write with its interrupt turned off
   sequence s_edge_off;
      io && !bus_req.rw && a[2] && !a[4] && !a[1];
   endsequence

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   ram_sel_a: assert property (ram_select == (bus_req.chip_select_high_active
      & ~bus_req.chip_select_low_active & ~bus_req.memory_space_select))
      else $error("ram select decode wrong");
   rd_drive_a: assert property (io && bus_req.rw |=> rdata_oe)
      else $error("section read not driven");
   no_drive_a: assert property (!(io && bus_req.rw) |=> !rdata_oe)
      else $error("data bus driven without read");
   flag_zero_a: assert property (fl |=> rdata[5:0] == 6'h00)
      else $error("flag read low bits not zero");
   edge_clr_a: assert property ($stable(port_a_in[7]) ##1 s_flag_rd ##1
      $stable(port_a_in[7]) ##1 s_flag_rd |=> !rdata[FLAG_EDGE_BIT])
      else $error("edge flag survived flag read");
   // No timer access between the two, or it could turn the timer back on
   irq_off_a: assert property (s_tmr_off ##1 !(io && a[2]) ##1 s_edge_off |=> !irq_n_oe)
      else $error("interrupt driven while disabled");
   port_dir_a: assert property (io && !bus_req.rw && !a[2] && a[1:0] == PORT_A_DIR
      |=> port_a_oe == $past(bus_req.wdata))
      else $error("port a direction not written");
   pb_read_a: assert property (io && bus_req.rw && !a[2] && a[1:0] == PORT_B_DIR
      |=> rdata == $past(port_b_oe))
      else $error("port b direction read wrong");
   init_clr_a: assert property (!init_in_n |=> (port_a_oe | port_a_out
      | port_b_oe | port_b_out) == '0)
      else $error("init left a port register set");
endmodule // riot_chk

bind ram_io_timer_edge_irq_unit riot_chk #(.DW(DW)) i_riot_chk (.clk(clk), .nrst(nrst),
   .init_in_n(init_in_n), .bus_req(bus_req), .rdata(rdata), .rdata_oe(rdata_oe),
   .ram_select(ram_select), .port_a_in(port_a_in), .port_a_out(port_a_out),
   .port_a_oe(port_a_oe), .port_b_out(port_b_out), .port_b_oe(port_b_oe),
   .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe));

// >>> bench/tb.sv
// Self-checking bench for the RAM, I/O and timer unit
`timescale 1ns/1ps
module tb
   import riot_pkg::*;
;
   logic clk = 1'b0; // 20 MHz clock
   logic nrst = 1'b0;
   logic init_in_n = 1'b1;
   logic [7:0] port_a_in = 8'h00; // Pins, bit 7 edge sense
   bus_req_s bus_req;
   logic [7:0] rdata, port_a_out, port_a_oe, port_b_out, port_b_oe, q;
   logic rdata_oe, ram_select, irq_n_out, irq_n_oe, oe;
   int err_count = 0;
   int checks_done = 0;
   int regs [4]; // Model of port registers
   int dv [4] = '{1, 8, 64, 1024}; // Divide per prescale code
   logic [31:0] r; // Random word

   always #25 clk = ~clk;

   ram_io_timer_edge_irq_unit #(.DW(8)) i_ram_io_timer_edge_irq_unit (.clk(clk),
      .nrst(nrst), .init_in_n(init_in_n), .bus_req(bus_req), .rdata(rdata),
      .rdata_oe(rdata_oe), .ram_select(ram_select), .port_a_in(port_a_in),
      .port_a_out(port_a_out), .port_a_oe(port_a_oe), .port_b_out(port_b_out),
      .port_b_oe(port_b_oe), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe));
   cpu_bus_model i_cpu_bus_model (.clk(clk), .rdata(rdata), .rdata_oe(rdata_oe),
      .bus_req(bus_req));

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         err_count++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      i_cpu_bus_model.xfer(3'h5, 1'b0, a, d, q, oe);
   endtask

   task automatic rd(input logic [6:0] a);
      i_cpu_bus_model.xfer(3'h5, 1'b1, a, 8'h00, q, oe);
   endtask

   // Move the edge pin, then check interrupt and flags
   task automatic pin_step(input logic v, input logic [7:0] ef, input logic ei);
      port_a_in[7] = v;
      repeat (3) @(negedge clk);
      chk({7'h00, irq_n_oe}, {7'h00, ei});
      chk({7'h00, irq_n_out}, 8'h00);
      rd(7'h05);
      chk(q, ef);
   endtask

   task automatic final_report;
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Watchdog
   // ---------------------------------------------------------------
   initial
   begin
      repeat (20000) @(posedge clk);
      err_count++;
      final_report;
   end

   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial
   begin
      r = $urandom(32'he3401032);
      repeat (5) @(negedge clk);
      nrst = 1'b1;
      // Only the I/O section answers
      for (int s = 0; s < 8; s++)
      begin
         i_cpu_bus_model.xfer(s[2:0], 1'b1, 7'h03, 8'h00, q, oe);
         chk({7'h00, oe}, {7'h00, s == 5});
      end
      $display("test decode done");
      // Port registers with random don't-care address bits
      for (int c = 0; c < 4; c++)
      begin
         r = $urandom;
         regs[c] = r[7:0];
         wr({r[14:11], 1'b0, c[1:0]}, r[7:0]);
      end
      port_a_in[6:0] = r[22:16];
      chk(port_a_out, 8'(regs[0]));
      chk(port_a_oe, 8'(regs[1]));
      chk(port_b_out, 8'(regs[2]));
      chk(port_b_oe, 8'(regs[3]));
      for (int c = 0; c < 4; c++)
      begin
         rd({5'h00, c[1:0]});
         chk(q, c == 0 ? port_a_in : 8'(regs[c]));
      end
      init_in_n = 1'b0;
      @(negedge clk);
      init_in_n = 1'b1;
      chk(port_a_oe | port_b_oe | port_a_out | port_b_out, 8'h00);
      $display("test ports done");
      // Count of three at every prescale, interrupt on
      foreach (dv[p])
      begin
         wr({3'h1, 2'h3, p[1:0]}, 8'h03);
         if (p > 0)
         begin
            rd(7'h0c);
            chk(q, 8'h03);
         end
         repeat (4 * dv[p] - (p > 0 ? 6 : 4)) @(negedge clk);
         rd(7'h05);
         chk(q, 8'h00);
         @(negedge clk);
         rd(7'h05);
         chk(q, 8'h80);
         chk({7'h00, irq_n_oe}, 8'h01);
         // Elapsed-time read, interrupt kept off afterwards
         rd(7'h04);
         chk({7'h00, q inside {[8'hfa:8'hfe]}}, 8'h01);
         chk({7'h00, irq_n_oe}, 8'h00);
         rd(7'h05);
         chk(q, 8'h00);
      end
      wr(7'h14, 8'h01);
      // Timer read lands in the very clock of expiry
      rd(7'h04);
      chk(q, 8'h00);
      rd(7'h05);
      chk(q, 8'h80);
      chk({7'h00, irq_n_oe}, 8'h00);
      wr(7'h1f, 8'hff);
      rd(7'h05);
      chk(q, 8'h00);
      $display("test timer done");
      // Every edge mode, random data and spare address bits
      for (int c = 0; c < 4; c++)
      begin
         r = $urandom;
         port_a_in[7] = c[0];
         if (c == 2)
            wr(7'h01, 8'h80);
         rd(7'h04);
         wr({r[9:8], 1'b0, r[10], 1'b1, c[1:0]}, r[7:0]);
         rd(7'h05);
         pin_step(~c[0], 8'h00, 1'b0);
         pin_step(c[0], 8'h40, c[1]);
         rd(7'h05);
         chk(q, 8'h00);
         chk({7'h00, irq_n_oe}, 8'h00);
      end
      init_in_n = 1'b0;
      @(negedge clk);
      init_in_n = 1'b1;
      pin_step(1'b0, 8'h40, 1'b0);
      pin_step(1'b1, 8'h00, 1'b0);
      $display("test edge done");
      final_report;
   end
endmodule // tb
